// ---- verif/data_source_model.sv ----
// Behavioural model of the sample source facing the block
`timescale 1ns/1ns
module data_source_model
   import steer_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              go,
   input  wire logic              is_b,
   input  wire logic [DATA_W-1:0] a_val,
   input  wire logic [DATA_W-1:0] b_val,
   output logic                   transmit_gate,
   output logic                   sample_marker,
   output logic      [DATA_W-1:0] a_channel_input,
   output logic      [DATA_W-1:0] b_channel_input
);
   // Pins idle at start
   initial begin
      transmit_gate = 1'b0;
      sample_marker = 1'b0;
      a_channel_input = 16'h0000;
      b_channel_input = 16'h0000;
   end
   // Gate and marker launched with their sample; idle buses churn
   always @(posedge clock) begin
      transmit_gate <= go;
      sample_marker <= go & is_b;
      a_channel_input <= go ? a_val : ~a_channel_input;
      b_channel_input <= go ? b_val : ~b_channel_input;
   end
endmodule

// ---- verif/input_steering_tb_top.sv ----
// Self-checking bench for the input steering block
`timescale 1ns/1ns
module input_steering_tb_top
   import steer_pkg::*;
;
   logic              clock = 1'b0, nrst = 1'b0, chip_reset_n = 1'b1, sleep = 1'b0, go = 1'b0, is_b = 1'b0;
   logic              phase_sync_strobe = 1'b0, pll_locked_in = 1'b0, config_select_n = 1'b1, config_data_in = 1'b0;
   logic              reg_write = 1'b0, reg_read = 1'b0, sink_ready = 1'b1, l;
   logic [ADDR_W-1:0] reg_addr = 6'h00;
   logic [7:0]        reg_wdata = 8'h00, reg_rdata;
   logic [DATA_W-1:0] av = 16'h0000, bv = 16'h0000, a_channel_input, b_channel_input;
   logic [DATA_W-1:0] a_true_code, a_comp_code, b_true_code, b_comp_code;
   logic              transmit_gate, sample_marker, sample_strobe, lock_indicator, powered_down;
   logic              config_data_oe, config_data_out, config_data_out_oe, input_stall;
   logic [3:0]        sync_init;
   logic [31:0]       q[$], e, seed = 32'h10E4;
   int                miscompares = 0, checked = 0, cycles = 0, wt;
   input_steering dut_u (.*);
   data_source_model src_u (.clock, .go, .is_b, .a_val(av), .b_val(bv), .transmit_gate, .sample_marker,
      .a_channel_input, .b_channel_input);
   // 100 MHz clock
   always #5 clock = ~clock;
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   // Expected code for a bus value
   function automatic logic [15:0] conv(input logic [15:0] x, input logic [7:0] c);
      logic [15:0] r;
      for (int k = 0; k < 16; k++) r[k] = c[BIT_REVERSE] ? x[15-k] : x[k];
      r[15] = r[15] ^ c[BIT_OFFSET_BIN];
      return r;
   endfunction
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
      checked++;
      if (g !== ex) begin
         $display("Error %s expected %h seen %h", nm, ex, g);
         miscompares++;
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] ex);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk("reg_rdata", ex, reg_rdata);
   endtask
   // Send n+6 samples, queueing expected pairs for the first n
   task automatic stream(input int n, input logic [7:0] cfg);
      logic [15:0] x, y, p;
      wr(OFS_INPUT_CFG, cfg);
      for (int i = 0; i < n + 6; i++) begin
         x = rnd();
         y = cfg[0] ? x : rnd();
         @(posedge clock);
         go <= 1'b1;
         av <= x;
         bv <= y;
         is_b <= cfg[0] & i[0];
         if (i < n && !cfg[0]) q.push_back({conv(x, cfg), conv(y, cfg)});
         if (i < n && cfg[0] && i[0]) q.push_back({conv(p, cfg), conv(x, cfg)});
         p = x;
      end
      @(posedge clock);
      go <= 1'b0;
      repeat (4) @(posedge clock);
      chk("pairs_left", 0, q.size());
   endtask
   task automatic complete_run();
      $display("miscompares %0d checked %0d", miscompares, checked);
      if (miscompares == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Output watcher takes the oldest expected pair
   always @(posedge clock) begin
      if (sample_strobe === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         chk("a_true_code", e[31:16], a_true_code);
         chk("b_true_code", e[15:0], b_true_code);
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         complete_run();
      end
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      rd(OFS_PORT_CFG, RST_PORT_CFG);
      rd(OFS_INPUT_CFG, RST_INPUT_CFG);
      rd(OFS_SYNC_CFG, RST_SYNC_CFG);
      rd(OFS_CLK_CFG, RST_CLK_CFG);
      rd(6'h3F, 8'h00);
      chk("sdo_oe", 0, config_data_out_oe);
      stream(10, 8'h00);
      stream(10, 8'h0C);
      stream(8, 8'h01);
      stream(7, 8'h01);
      stream(8, 8'h03);
      wr(OFS_SYNC_CFG, 8'h05);
      @(posedge clock) phase_sync_strobe <= 1'b1;
      @(posedge clock) phase_sync_strobe <= 1'b0;
      for (wt = 0; sync_init === 4'h0 && wt < 4; wt++) @(posedge clock);
      chk("sync_init", 5, sync_init);
      pll_locked_in <= 1'b1;
      repeat (12) @(posedge clock);
      chk("lock_early", 0, lock_indicator);
      repeat (8) @(posedge clock);
      chk("lock", 1, lock_indicator);
      wr(OFS_CLK_CFG, 8'h00);
      repeat (3) @(posedge clock);
      l = lock_indicator;
      @(posedge clock);
      chk("lock_clock", !l, lock_indicator);
      sink_ready <= 1'b0;
      go <= 1'b1;
      for (wt = 0; input_stall !== 1'b1 && wt < 12; wt++) @(posedge clock);
      chk("stall", 1, input_stall);
      sink_ready <= 1'b1;
      go <= 1'b0;
      repeat (8) @(posedge clock);
      chk("stall_off", 0, input_stall);
      @(posedge clock) sleep <= 1'b1;
      #1 chk("powered_down", 1, powered_down);
      @(posedge clock) sleep <= 1'b0;
      wr(OFS_PORT_CFG, 8'h02);
      for (int i = 0; i < 6; i++) begin
         @(posedge clock);
         config_select_n <= i[2];
         config_data_in <= rnd() > 16'h7FFF;
         if (i == 3) chk("sdo_drive", 1, config_data_out_oe);
      end
      @(posedge clock) chip_reset_n <= 1'b0;
      @(posedge clock) chip_reset_n <= 1'b1;
      rd(OFS_PORT_CFG, RST_PORT_CFG);
      rd(OFS_CLK_CFG, RST_CLK_CFG);
      chk("sdo_oe_reset", 0, config_data_out_oe);
      complete_run();
   end
endmodule

// ---- verif/steer_checker_assertions.sv ----
// Assertion checker for the input steering block
`timescale 1ns/1ns
module steer_checker
   import steer_pkg::*;
(
   input wire logic              clock,
   input wire logic              nrst,
   input wire logic              chip_reset_n,
   input wire logic              sleep,
   input wire logic              transmit_gate,
   input wire logic              phase_sync_strobe,
   input wire logic              pll_locked_in,
   input wire logic              config_select_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_write,
   input wire logic [DATA_W-1:0] a_true_code,
   input wire logic [DATA_W-1:0] a_comp_code,
   input wire logic [DATA_W-1:0] b_true_code,
   input wire logic [DATA_W-1:0] b_comp_code,
   input wire logic              sample_strobe,
   input wire logic              lock_indicator,
   input wire logic              powered_down,
   input wire logic [3:0]        sync_init,
   input wire logic              config_data_oe,
   input wire logic              config_data_out_oe
);
   logic [1:0] clk_q;    // Clock mode copy
   logic       four_q;   // Four-pin copy
   logic [3:0] sync_q;   // Sync target copy
   logic [4:0] lock_cnt; // Run of lock input
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // Follow register writes
   always_ff @(posedge clock) begin
      if (!nrst || !chip_reset_n) begin
         clk_q  <= RST_CLK_CFG[1:0];
         four_q <= RST_PORT_CFG[BIT_FOUR_PIN];
         sync_q <= RST_SYNC_CFG[3:0];
      end else if (reg_write) begin
         if (reg_addr == OFS_CLK_CFG) clk_q <= reg_wdata[1:0];
         if (reg_addr == OFS_PORT_CFG) four_q <= reg_wdata[BIT_FOUR_PIN];
         if (reg_addr == OFS_SYNC_CFG) sync_q <= reg_wdata[3:0];
      end
   end
   // Count consecutive lock input cycles
   always_ff @(posedge clock) begin
      if (!nrst || !chip_reset_n || !pll_locked_in) lock_cnt <= 5'h00;
      else if (lock_cnt != 5'h1F) lock_cnt <= lock_cnt + 5'h01;
   end
   sequence gate_off_s;
      !transmit_gate [*2];
   endsequence
   gate_zero_a: assert property (gate_off_s |=> a_true_code == '0 && b_true_code == '0 && !sample_strobe)
      else $error("outputs not zero with gate low");
   gate_pass_a: assert property (sample_strobe |-> $past(transmit_gate, 2))
      else $error("sample without gate");
   comp_code_a: assert property (sample_strobe |-> a_comp_code == ~a_true_code && b_comp_code == ~b_true_code)
      else $error("complement code wrong");
   sleep_down_a: assert property (sleep |-> powered_down)
      else $error("sleep did not power down");
   chip_reset_a: assert property (!chip_reset_n |=> a_true_code == '0 && !sample_strobe && sync_init == '0)
      else $error("chip reset left outputs");
   sync_mask_a: assert property (sync_init != '0 |-> (sync_init & ~sync_q) == '0
      && ($past(phase_sync_strobe) || $past(phase_sync_strobe, 2)))
      else $error("sync init not selected");
   lock_high_a: assert property (clk_q == 2'b01 && lock_cnt >= 5'd18 |-> lock_indicator)
      else $error("lock not shown");
   lock_low_a: assert property (clk_q == 2'b01 && lock_cnt == 5'd0 && $past(lock_cnt) == 5'd0 |-> !lock_indicator)
      else $error("lock shown without input");
   ext_clock_a: assert property (!clk_q[0] && $past(clk_q, 3) == 2'b00 |-> lock_indicator != $past(lock_indicator))
      else $error("lock pin not toggling");
   sdo_tristate_a: assert property (!four_q && !$past(four_q) |-> !config_data_out_oe)
      else $error("serial output driven in three-pin mode");
   four_pin_a: assert property (four_q && $past(four_q) |-> !config_data_oe)
      else $error("data pin driven in four-pin mode");
   select_idle_a: assert property (config_select_n && $past(config_select_n) |-> !config_data_oe && !config_data_out_oe)
      else $error("port driven while unselected");
endmodule
bind input_steering steer_checker chk_u (.*);

// ---- verilog/input_steering.sv ----
// Dual-channel input gating, steering and control pins
//
// Overview of operation
// - Samples pass only while transmit gate high
// - Gate low forces datapath zero, ignores inputs
// - Edge-alternation: A first after rising gate
// - Marker mode: marker high routes to B
// - Chip reset low resets all but the sleep logic
// - Sleep powers down without any clock
// - Sync strobe initialises selected sub-blocks
// - PLL mode: lock pin shows lock or clock
// - External mode: lock pin shows data clock
// - True output full scale at all ones
// - Select low enables a port transaction
// - Three-pin default; data pin bidirectional
// - Serial output driven only in four-pin mode
// - Bus bit order reversible by register
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module input_steering
   import steer_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              chip_reset_n,
   input  wire logic              sleep,
   input  wire logic              transmit_gate,
   input  wire logic              sample_marker,
   input  wire logic [DATA_W-1:0] a_channel_input,
   input  wire logic [DATA_W-1:0] b_channel_input,
   input  wire logic              phase_sync_strobe,
   input  wire logic              pll_locked_in,
   input  wire logic              config_select_n,
   input  wire logic              config_data_in,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   input  wire logic              sink_ready,
   output logic      [7:0]        reg_rdata,
   output logic      [DATA_W-1:0] a_true_code,
   output logic      [DATA_W-1:0] a_comp_code,
   output logic      [DATA_W-1:0] b_true_code,
   output logic      [DATA_W-1:0] b_comp_code,
   output logic                   sample_strobe,
   output logic                   lock_indicator,
   output logic                   powered_down,
   output logic      [3:0]        sync_init,
   output logic                   config_data_oe,
   output logic                   config_data_out,
   output logic                   config_data_out_oe,
   output logic                   input_stall
);
   // ***************************************************************
   // Bit-order helper
   // ***************************************************************
   // Reverses a bus when asked
   function automatic logic [DATA_W-1:0] order_bus(input logic [DATA_W-1:0] d, input logic rev);
      logic [DATA_W-1:0] r;
      r = '0;
      for (int i = 0; i < DATA_W; i++) begin
         r[i] = d[DATA_W-1-i];
      end
      return rev ? r : d;
   endfunction

   // ***************************************************************
   // Reset and sleep
   // ***************************************************************
   logic rst_all;                          // Combined reset, active high
   logic sleep_q1_reg;                     // Sleep synchroniser stage 1
   logic sleep_q2_reg;                     // Sleep synchroniser stage 2
   assign rst_all = !nrst || !chip_reset_n;

   // Sleep is resolved through two flops for the clocked logic
   always_ff @(posedge clock) begin
      sleep_q1_reg <= sleep;
      sleep_q2_reg <= sleep_q1_reg;
   end

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   logic [7:0] port_cfg_reg;               // Serial port mode
   logic [7:0] input_cfg_reg;              // Input format
   logic [7:0] sync_cfg_reg;               // Sync targets
   logic [7:0] clk_cfg_reg;                // Clock mode
   logic [7:0] status_word;                // Live status for readback

   // Register writes
   always_ff @(posedge clock) begin
      if (rst_all) begin
         port_cfg_reg  <= RST_PORT_CFG;
         input_cfg_reg <= RST_INPUT_CFG;
         sync_cfg_reg  <= RST_SYNC_CFG;
         clk_cfg_reg   <= RST_CLK_CFG;
      end else if (reg_write) begin
         unique case (reg_addr)
            OFS_PORT_CFG:  port_cfg_reg  <= reg_wdata;
            OFS_INPUT_CFG: input_cfg_reg <= reg_wdata;
            OFS_SYNC_CFG:  sync_cfg_reg  <= reg_wdata;
            OFS_CLK_CFG:   clk_cfg_reg   <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Register reads, data the cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst_all) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            OFS_PORT_CFG:  reg_rdata <= port_cfg_reg;
            OFS_INPUT_CFG: reg_rdata <= input_cfg_reg;
            OFS_SYNC_CFG:  reg_rdata <= sync_cfg_reg;
            OFS_CLK_CFG:   reg_rdata <= clk_cfg_reg;
            OFS_STATUS:    reg_rdata <= status_word;
            default:       reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   logic interleave;                       // Interleaved input mode
   logic marker_sel;                       // Marker-based steering
   logic reverse;                          // Bit-order reversal
   logic offset_bin;                       // Two's complement input
   logic pll_mode;                         // PLL clock mode
   assign interleave = input_cfg_reg[BIT_INTERLEAVE];
   assign marker_sel = input_cfg_reg[BIT_MARKER_SEL];
   assign reverse    = input_cfg_reg[BIT_REVERSE];
   assign offset_bin = input_cfg_reg[BIT_OFFSET_BIN];
   assign pll_mode   = clk_cfg_reg[BIT_PLL_MODE];

   // ***************************************************************
   // Input capture
   // ***************************************************************
   logic [DATA_W-1:0] a_in_reg;            // Captured A bus
   logic [DATA_W-1:0] b_in_reg;            // Captured B bus
   logic              gate_reg;            // Gate with this sample
   logic              gate_prev_reg;       // Gate one sample earlier
   logic              marker_reg;          // Marker with this sample

   // Gate, marker and data share one edge
   always_ff @(posedge clock) begin
      if (rst_all) begin
         a_in_reg      <= '0;
         b_in_reg      <= '0;
         gate_reg      <= 1'b0;
         gate_prev_reg <= 1'b0;
         marker_reg    <= 1'b0;
      end else if (!input_stall) begin
         a_in_reg      <= order_bus(a_channel_input, reverse);
         b_in_reg      <= order_bus(b_channel_input, reverse);
         gate_reg      <= transmit_gate;
         gate_prev_reg <= gate_reg;
         marker_reg    <= sample_marker;
      end
   end

   // ***************************************************************
   // Channel steering
   // ***************************************************************
   steer_state_t      steer_reg;           // Next channel to fill
   steer_state_t      steer_next;
   logic [DATA_W-1:0] hold_a_reg;          // A half of an interleaved pair
   logic              to_b;                // Current sample is a B sample
   logic              pair_done;           // Pair complete this cycle
   logic              gate_rise;           // First gated sample

   assign gate_rise = gate_reg && !gate_prev_reg;
   // Choose destination channel
   always_comb begin
      if (marker_sel) begin
         to_b = marker_reg;
      end else begin
         to_b = gate_rise ? 1'b0 : (steer_reg == EXPECT_B);
      end
      steer_next = to_b ? EXPECT_A : EXPECT_B;
      pair_done  = gate_reg && (!interleave || to_b);
   end

   // Steering state update
   always_ff @(posedge clock) begin
      if (rst_all) begin
         steer_reg <= EXPECT_A;
      end else if (!gate_reg) begin
         steer_reg <= EXPECT_A;
      end else if (interleave && !input_stall) begin
         steer_reg <= steer_next;
      end
   end

   // Hold the A sample awaiting its B partner
   always_ff @(posedge clock) begin
      if (rst_all || !gate_reg) begin
         hold_a_reg <= '0;
      end else if (interleave && !to_b && !input_stall) begin
         hold_a_reg <= a_in_reg;
      end
   end

   // ***************************************************************
   // Input FIFO
   // ***************************************************************
   logic [2*DATA_W-1:0] fifo_in;           // A and B words
   logic [2*DATA_W-1:0] fifo_out;
   logic                fifo_in_valid;
   logic                fifo_in_ready;
   logic                fifo_out_valid;
   logic                fifo_flush;        // Clear on sync when selected or gate low

   assign fifo_in       = interleave ? {hold_a_reg, a_in_reg} : {a_in_reg, b_in_reg};
   assign fifo_in_valid = pair_done && !sleep_q2_reg;
   assign fifo_flush    = !gate_reg || (phase_sync_strobe && sync_cfg_reg[3]);

   sample_fifo #(
      .WIDTH (2 * DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .nrst      (!rst_all),
      .flush     (fifo_flush),
      .in_data   (fifo_in),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_out_valid),
      .out_ready (sink_ready)
   );

   // Stall capture while the FIFO is full and the sink is not ready
   always_ff @(posedge clock) begin
      if (rst_all) begin
         input_stall <= 1'b0;
      end else begin
         input_stall <= !fifo_in_ready && !sink_ready;
      end
   end

   // ***************************************************************
   // Output codes
   // ***************************************************************
   logic [DATA_W-1:0] a_code;              // Unsigned A code
   logic [DATA_W-1:0] b_code;              // Unsigned B code
   logic [DATA_W-1:0] msb_flip;            // MSB inversion mask
   assign msb_flip = {offset_bin, {(DATA_W-1){1'b0}}};
   assign a_code   = fifo_out[2*DATA_W-1:DATA_W] ^ msb_flip;
   assign b_code   = fifo_out[DATA_W-1:0] ^ msb_flip;

   // True and complementary codes
   always_ff @(posedge clock) begin
      if (rst_all || !gate_reg || sleep_q2_reg) begin
         a_true_code   <= '0;
         a_comp_code   <= '0;
         b_true_code   <= '0;
         b_comp_code   <= '0;
         sample_strobe <= 1'b0;
      end else if (fifo_out_valid && sink_ready) begin
         a_true_code   <= a_code;
         a_comp_code   <= ~a_code;
         b_true_code   <= b_code;
         b_comp_code   <= ~b_code;
         sample_strobe <= 1'b1;
      end else begin
         sample_strobe <= 1'b0;
      end
   end

   // ***************************************************************
   // Phase sync, clock divider and lock indicator
   // ***************************************************************
   logic       div_reg;                    // Data-rate clock divider
   logic [3:0] lock_cnt_reg;               // Lock qualification count
   logic       locked;

   // Sync pulse to the selected targets
   always_ff @(posedge clock) begin
      if (rst_all) begin
         sync_init <= 4'h0;
      end else begin
         sync_init <= phase_sync_strobe ? sync_cfg_reg[3:0] : 4'h0;
      end
   end

   // Divider, restarted by sync when selected
   always_ff @(posedge clock) begin
      if (rst_all || (phase_sync_strobe && sync_cfg_reg[2])) begin
         div_reg <= 1'b0;
      end else begin
         div_reg <= !div_reg;
      end
   end

   // Lock must hold for a while before shown
   always_ff @(posedge clock) begin
      if (rst_all || !pll_locked_in) begin
         lock_cnt_reg <= 4'h0;
      end else if (!locked) begin
         lock_cnt_reg <= lock_cnt_reg + 4'h1;
      end
   end
   assign locked = (lock_cnt_reg == LOCK_CYCLES);

   // Lock pin source select
   always_ff @(posedge clock) begin
      if (rst_all) begin
         lock_indicator <= 1'b0;
      end else if (!pll_mode) begin
         lock_indicator <= div_reg;
      end else if (clk_cfg_reg[BIT_LOCK_CLKOUT]) begin
         lock_indicator <= div_reg;
      end else begin
         lock_indicator <= locked;
      end
   end

   // Sleep state sets with the pin with no clock needed, clears on a clock
   always_ff @(posedge clock or posedge sleep) begin
      if (sleep) begin
         powered_down <= 1'b1;
      end else begin
         powered_down <= 1'b0;
      end
   end

   // ***************************************************************
   // Serial port pin modes
   // ***************************************************************
   logic four_pin;                          // Four-pin port mode
   logic rd_bit_reg;                        // Shifted read bit
   assign four_pin = port_cfg_reg[BIT_FOUR_PIN];

   // Read bit is status bit 0 XOR the data pin while selected
   always_ff @(posedge clock) begin
      if (rst_all || config_select_n) begin
         rd_bit_reg <= 1'b0;
      end else begin
         rd_bit_reg <= status_word[0] ^ config_data_in;
      end
   end

   // Drivers and enables of the port pins
   always_ff @(posedge clock) begin
      if (rst_all) begin
         config_data_oe     <= 1'b0;
         config_data_out    <= 1'b0;
         config_data_out_oe <= 1'b0;
      end else begin
         config_data_oe     <= !four_pin && !config_select_n;
         config_data_out    <= rd_bit_reg;
         config_data_out_oe <= four_pin && !config_select_n;
      end
   end

   assign status_word = {3'h0, powered_down, input_stall, fifo_out_valid, steer_reg == EXPECT_B, locked};
endmodule

// ---- verilog/sample_fifo.sv ----
// Small valid/ready FIFO of flip-flops
`timescale 1ns/1ns
module sample_fifo #(
   parameter int unsigned WIDTH = 33,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned PW = $clog2(DEPTH);
   // ***************************************************************
   // Storage and pointers
   // ***************************************************************
   logic [WIDTH-1:0] mem_reg [DEPTH];    // Word store
   logic [PW-1:0]    wr_ptr_reg;         // Write index
   logic [PW-1:0]    rd_ptr_reg;         // Read index
   logic [PW:0]      count_reg;          // Words held
   logic             push;
   logic             pop;
   assign in_ready  = (count_reg != (PW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   // Write side
   always_ff @(posedge clock) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end
   // Pointers and count
   always_ff @(posedge clock) begin
      if (!nrst || flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

// ---- verilog/steer_pkg.sv ----
// Package of constants for the dual-channel input steering block
package steer_pkg;
   // ***************************************************************
   // Widths
   // ***************************************************************
   localparam int unsigned DATA_W       = 16;        // Input bus width
   localparam int unsigned FIFO_DEPTH   = 4;         // Words in the input FIFO
   localparam int unsigned ADDR_W       = 6;         // Register address width
   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [5:0]  OFS_PORT_CFG  = 6'h08;    // Serial port mode
   localparam logic [5:0]  OFS_INPUT_CFG = 6'h01;    // Input format
   localparam logic [5:0]  OFS_SYNC_CFG  = 6'h02;    // Sync targets
   localparam logic [5:0]  OFS_CLK_CFG   = 6'h03;    // Clock mode
   localparam logic [5:0]  OFS_STATUS    = 6'h04;    // Block state
   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int unsigned BIT_FOUR_PIN    = 1;      // 1 = four-pin port
   localparam int unsigned BIT_INTERLEAVE  = 0;      // Interleaved input mode
   localparam int unsigned BIT_MARKER_SEL  = 1;      // Marker-based steering
   localparam int unsigned BIT_REVERSE     = 2;      // Reverse bus bit order
   localparam int unsigned BIT_OFFSET_BIN  = 3;      // Invert MSB (two's compl)
   localparam int unsigned BIT_PLL_MODE    = 0;      // 1 = PLL clock mode
   localparam int unsigned BIT_LOCK_CLKOUT = 1;      // Show clock on lock pin
   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0]  RST_PORT_CFG  = 8'h00;    // Three-pin mode
   localparam logic [7:0]  RST_INPUT_CFG = 8'h00;
   localparam logic [7:0]  RST_SYNC_CFG  = 8'h0F;    // All sync targets
   localparam logic [7:0]  RST_CLK_CFG   = 8'h01;    // PLL mode
   // ***************************************************************
   // Counts
   // ***************************************************************
   localparam logic [3:0]  LOCK_CYCLES   = 4'hF;     // Cycles to declare lock
   // Steering state
   typedef enum logic [0:0] {
      EXPECT_A = 1'b0,
      EXPECT_B = 1'b1
   } steer_state_t;
endpackage
